// *** inc/ecs_pkg.sv ***
package ecs_pkg;

  // array window and storage layout
  localparam logic [15:0] ARRAY_BASE   = 16'h0600;
  localparam logic [15:0] ARRAY_LAST   = 16'h07ff;
  localparam int          ARRAY_BYTES  = 512;
  localparam int          NV_SLOTS     = 3;
  localparam int          MEM_AW       = 10;
  localparam int          MEM_DEPTH    = ARRAY_BYTES + NV_SLOTS;
  localparam logic [9:0]  NV_IDX_CFG   = 10'h200;
  localparam logic [9:0]  NV_IDX_DIVH  = 10'h201;
  localparam logic [9:0]  NV_IDX_DIVL  = 10'h202;
  localparam logic [9:0]  LAST_ARR_IDX = 10'h1ff;
  localparam logic [6:0]  BLK_LAST_OFS = 7'h7f;
  localparam logic [1:0]  LD_LAST      = 2'h2;
  localparam logic [7:0]  ERASED_BYTE  = 8'hff;

  // array configuration byte fields
  localparam int          BP_LSB       = 0;
  localparam int          BP_W         = 4;
  localparam int          RDPROT_BIT   = 4;

  // shadow reset values, overwritten by the load after reset
  localparam logic [7:0]  CFG_RESET    = 8'hff;
  localparam logic [15:0] DIV_RESET    = 16'hffff;
  localparam logic [3:0]  BP_RESET     = 4'hf;

  typedef enum logic [2:0] {
    OP_READ        = 3'h0,
    OP_PROG        = 3'h1,
    OP_ERASE_BYTE  = 3'h2,
    OP_ERASE_BLOCK = 3'h3,
    OP_ERASE_BULK  = 3'h4
  } ecs_op_type;

  typedef enum logic [1:0] {
    TGT_ARRAY   = 2'h0,
    TGT_NV_CFG  = 2'h1,
    TGT_NV_DIVH = 2'h2,
    TGT_NV_DIVL = 2'h3
  } ecs_tgt_type;

  typedef enum logic [1:0] {
    SHD_CFG  = 2'h0,
    SHD_DIVH = 2'h1,
    SHD_DIVL = 2'h2
  } ecs_shd_sel_type;

  typedef struct packed {
    logic        valid;
    ecs_op_type  op;
    ecs_tgt_type tgt;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } ecs_req_type;

  typedef struct packed {
    logic            valid;
    ecs_shd_sel_type sel;
    logic [7:0]      data;
  } ecs_shd_type;

  typedef enum logic [7:0] {
    S_LD_ADDR = 8'h01,
    S_LD_DATA = 8'h02,
    S_IDLE    = 8'h04,
    S_READ    = 8'h08,
    S_PRG_RD  = 8'h10,
    S_HV      = 8'h20,
    S_WRITE   = 8'h40,
    S_ERASE   = 8'h80
  } ecs_state_type;

endpackage

// *** design/ecs_nv_mem.sv ***
`timescale 1ns/1ps
module ecs_nv_mem #(
  parameter int AW    = 10,
  parameter int DEPTH = 515,
  parameter int DW    = 8
) (
  input  wire logic          clk_in,
  input  wire logic [AW-1:0] addr_in,
  input  wire logic          we_in,
  input  wire logic [DW-1:0] wdata_in,
  output logic      [DW-1:0] rdata_out
);

  generate
    if (DEPTH > (1 << AW) || DEPTH < 1)
    begin : g_bad_depth
      $error("ecs_nv_mem: depth does not fit address width");
    end
  endgenerate

  logic [DW-1:0] mem_ff [DEPTH];

  // erased cells read all ones, as shipped
  initial
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      mem_ff[i] = {DW{1'b1}};
    end
  end

  // plain always: the erased preset above is a second writer of the array
  always @(posedge clk_in)
  begin
    if (we_in)
    begin
      mem_ff[addr_in] <= wdata_in;
    end
    rdata_out <= mem_ff[addr_in];
  end

endmodule

// *** design/ecs_config_loader.sv ***
`timescale 1ns/1ps
module ecs_config_loader #(
  parameter int HV_TICKS = 8
) (
  input  wire logic                CLK_SYS_IN,
  input  wire logic                RST_N_IN,
  input  wire ecs_pkg::ecs_req_type MEM_REQ_IN,
  input  wire ecs_pkg::ecs_shd_type SHADOW_WR_IN,
  input  wire logic                AUTO_TIMING_IN,
  input  wire logic                HV_STOP_IN,
  input  wire logic                MONITOR_MODE_IN,
  output logic                     MEM_ACK_OUT,
  output logic                     MEM_ERR_OUT,
  output logic [7:0]               MEM_RDATA_OUT,
  output logic [7:0]               ARRAY_CONFIG_OUT,
  output logic [15:0]              TIMEBASE_DIVIDER_OUT,
  output logic [3:0]               BLOCK_PROTECT_OUT,
  output logic                     CONFIG_VALID_OUT,
  output logic                     TIMEBASE_TICK_OUT,
  output logic                     PUMP_ON_OUT,
  output logic                     BUSY_OUT
);

  localparam int HW = $clog2(HV_TICKS + 1);
  localparam logic [HW-1:0] HV_LAST = HW'(HV_TICKS - 1);

  generate
    if (HV_TICKS < 1)
    begin : g_bad_ticks
      $error("ecs_config_loader: HV_TICKS must be at least 1");
    end
  endgenerate

  ecs_pkg::ecs_state_type st_ff;
  ecs_pkg::ecs_state_type nxt_st;
  ecs_pkg::ecs_op_type    op_ff;
  logic [1:0]             ld_idx_ff;
  logic [7:0]             cfg_ff;
  logic [15:0]            div_ff;
  logic [3:0]             bp_ff;
  logic [9:0]             cur_idx_ff;
  logic [9:0]             end_idx_ff;
  logic [7:0]             wdata_ff;
  logic [7:0]             prog_ff;
  logic                   auto_ff;
  logic                   nv_cfg_rd_ff;
  logic [HW-1:0]          hv_cnt_ff;
  logic [15:0]            tb_cnt_ff;
  logic                   tick_ff;
  logic                   ack_ff;
  logic                   err_ff;
  logic [7:0]             rdata_ff;
  logic                   valid_ff;
  logic                   pump_ff;
  logic                   busy_ff;
  logic [7:0]             mem_rd;

  ecs_pkg::ecs_req_type req;
  logic       accept;
  logic       in_window;
  logic       is_array;
  logic [9:0] nv_idx;
  logic [9:0] req_idx;
  logic       blk_locked;
  logic       is_erase;
  logic       is_write;
  logic       range_op;
  logic       rd_locked;
  logic       req_bad;
  logic [9:0] start_idx;
  logic [9:0] stop_idx;
  logic       erase_locked;
  logic       erase_last;
  logic       hv_done;
  logic [9:0] mem_addr;
  logic       mem_we;
  logic [7:0] mem_wd;
  logic [15:0] div_m1;
  logic       shd_wr;

  assign req        = MEM_REQ_IN;
  // no take in the ack cycle: the requester drops valid on the edge that sees ack
  assign accept     = (st_ff == ecs_pkg::S_IDLE) && req.valid && !ack_ff;
  assign in_window  = (req.addr >= ecs_pkg::ARRAY_BASE) && (req.addr <= ecs_pkg::ARRAY_LAST);
  assign is_array   = (req.tgt == ecs_pkg::TGT_ARRAY);
  assign nv_idx     = (req.tgt == ecs_pkg::TGT_NV_CFG)  ? ecs_pkg::NV_IDX_CFG :
                      (req.tgt == ecs_pkg::TGT_NV_DIVH) ? ecs_pkg::NV_IDX_DIVH : ecs_pkg::NV_IDX_DIVL;
  // nv cells share the array's storage and program/erase path
  assign req_idx    = is_array ? {1'b0, req.addr[8:0]} : nv_idx;
  assign blk_locked = is_array && bp_ff[req.addr[8:7]];
  assign is_erase   = (req.op == ecs_pkg::OP_ERASE_BYTE) || range_op;
  assign range_op   = (req.op == ecs_pkg::OP_ERASE_BLOCK) || (req.op == ecs_pkg::OP_ERASE_BULK);
  assign is_write   = (req.op == ecs_pkg::OP_PROG) || is_erase;
  assign rd_locked  = (req.op == ecs_pkg::OP_READ) && is_array && MONITOR_MODE_IN
                      && cfg_ff[ecs_pkg::RDPROT_BIT];
  // bulk erase skips locked blocks instead of refusing outright
  assign req_bad    = (is_array && !in_window)
                      || (is_write && blk_locked && req.op != ecs_pkg::OP_ERASE_BULK)
                      || (range_op && !is_array)
                      || rd_locked
                      || (req.op > ecs_pkg::OP_ERASE_BULK);
  assign start_idx  = (req.op == ecs_pkg::OP_ERASE_BULK)  ? 10'h000 :
                      (req.op == ecs_pkg::OP_ERASE_BLOCK) ? {1'b0, req.addr[8:7], 7'h00} : req_idx;
  assign stop_idx   = (req.op == ecs_pkg::OP_ERASE_BULK)  ? ecs_pkg::LAST_ARR_IDX :
                      (req.op == ecs_pkg::OP_ERASE_BLOCK) ? {1'b0, req.addr[8:7], ecs_pkg::BLK_LAST_OFS} : req_idx;
  assign erase_locked = !cur_idx_ff[9] && bp_ff[cur_idx_ff[8:7]];
  assign erase_last = (cur_idx_ff == end_idx_ff);
  // manual mode waits for software to end the pulse
  assign hv_done    = auto_ff ? (tick_ff && hv_cnt_ff == HV_LAST) : HV_STOP_IN;
  assign mem_addr   = (st_ff == ecs_pkg::S_LD_ADDR) ? ecs_pkg::NV_IDX_CFG + {8'h00, ld_idx_ff} :
                      (st_ff == ecs_pkg::S_IDLE)    ? req_idx : cur_idx_ff;
  assign mem_we     = (st_ff == ecs_pkg::S_WRITE) || (st_ff == ecs_pkg::S_ERASE && !erase_locked);
  assign mem_wd     = (st_ff == ecs_pkg::S_ERASE) ? ecs_pkg::ERASED_BYTE : prog_ff;
  assign div_m1     = (div_ff == 16'h0000) ? 16'h0000 : div_ff - 16'h0001;
  assign shd_wr     = SHADOW_WR_IN.valid && valid_ff;

  ecs_nv_mem #(
    .AW    (ecs_pkg::MEM_AW),
    .DEPTH (ecs_pkg::MEM_DEPTH),
    .DW    (8)
  ) u_mem (
    .clk_in    (CLK_SYS_IN),
    .addr_in   (mem_addr),
    .we_in     (mem_we),
    .wdata_in  (mem_wd),
    .rdata_out (mem_rd)
  );

  always_comb
  begin
    nxt_st = st_ff;
    case (st_ff)
      ecs_pkg::S_LD_ADDR: nxt_st = ecs_pkg::S_LD_DATA;
      ecs_pkg::S_LD_DATA: nxt_st = (ld_idx_ff == ecs_pkg::LD_LAST) ? ecs_pkg::S_IDLE : ecs_pkg::S_LD_ADDR;
      ecs_pkg::S_IDLE:
      begin
        if (accept && !req_bad)
        begin
          if (req.op == ecs_pkg::OP_READ)
            nxt_st = ecs_pkg::S_READ;
          else if (req.op == ecs_pkg::OP_PROG)
            nxt_st = ecs_pkg::S_PRG_RD;
          else
            nxt_st = ecs_pkg::S_HV;
        end
      end
      ecs_pkg::S_READ:   nxt_st = ecs_pkg::S_IDLE;
      ecs_pkg::S_PRG_RD: nxt_st = ecs_pkg::S_HV;
      ecs_pkg::S_HV:
      begin
        if (hv_done)
          nxt_st = (op_ff == ecs_pkg::OP_PROG) ? ecs_pkg::S_WRITE : ecs_pkg::S_ERASE;
      end
      ecs_pkg::S_WRITE:  nxt_st = ecs_pkg::S_IDLE;
      ecs_pkg::S_ERASE:  nxt_st = erase_last ? ecs_pkg::S_IDLE : ecs_pkg::S_ERASE;
      default:           nxt_st = ecs_pkg::S_LD_ADDR;
    endcase
  end

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
    begin
      st_ff     <= ecs_pkg::S_LD_ADDR;
      ld_idx_ff <= 2'h0;
      valid_ff  <= 1'b0;
      pump_ff   <= 1'b0;
      busy_ff   <= 1'b1;
    end
    else
    begin
      st_ff     <= nxt_st;
      ld_idx_ff <= (st_ff == ecs_pkg::S_LD_DATA) ? ld_idx_ff + 2'h1 : ld_idx_ff;
      valid_ff  <= (nxt_st != ecs_pkg::S_LD_ADDR) && (nxt_st != ecs_pkg::S_LD_DATA);
      pump_ff   <= (nxt_st == ecs_pkg::S_HV);
      busy_ff   <= (nxt_st != ecs_pkg::S_IDLE);
    end
  end

  // shadows: reset load first, then software writes
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
    begin
      cfg_ff <= ecs_pkg::CFG_RESET;
      div_ff <= ecs_pkg::DIV_RESET;
      bp_ff  <= ecs_pkg::BP_RESET;
    end
    else if (st_ff == ecs_pkg::S_LD_DATA)
    begin
      case (ld_idx_ff)
        2'h0:
        begin
          cfg_ff <= mem_rd;
          bp_ff  <= mem_rd[ecs_pkg::BP_LSB +: ecs_pkg::BP_W];
        end
        2'h1:    div_ff[15:8] <= mem_rd;
        default: div_ff[7:0]  <= mem_rd;
      endcase
    end
    else
    begin
      if (shd_wr && SHADOW_WR_IN.sel == ecs_pkg::SHD_CFG)
        cfg_ff <= SHADOW_WR_IN.data;
      if (shd_wr && SHADOW_WR_IN.sel == ecs_pkg::SHD_DIVH)
        div_ff[15:8] <= SHADOW_WR_IN.data;
      if (shd_wr && SHADOW_WR_IN.sel == ecs_pkg::SHD_DIVL)
        div_ff[7:0] <= SHADOW_WR_IN.data;
      if (st_ff == ecs_pkg::S_READ && nv_cfg_rd_ff)
        bp_ff <= mem_rd[ecs_pkg::BP_LSB +: ecs_pkg::BP_W];
    end
  end

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
    begin
      ack_ff   <= 1'b0;
      err_ff   <= 1'b0;
      rdata_ff <= 8'h00;
    end
    else
    begin
      ack_ff   <= (accept && req_bad) || (st_ff == ecs_pkg::S_READ) || (st_ff == ecs_pkg::S_WRITE)
                  || (st_ff == ecs_pkg::S_ERASE && erase_last);
      err_ff   <= accept && req_bad;
      rdata_ff <= (st_ff == ecs_pkg::S_READ) ? mem_rd : (accept && req_bad) ? 8'h00 : rdata_ff;
    end
  end

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
    begin
      op_ff        <= ecs_pkg::OP_READ;
      cur_idx_ff   <= 10'h000;
      end_idx_ff   <= 10'h000;
      wdata_ff     <= 8'h00;
      auto_ff      <= 1'b0;
      nv_cfg_rd_ff <= 1'b0;
      prog_ff      <= 8'h00;
    end
    else if (accept)
    begin
      op_ff        <= req.op;
      cur_idx_ff   <= start_idx;
      end_idx_ff   <= stop_idx;
      wdata_ff     <= req.wdata;
      auto_ff      <= AUTO_TIMING_IN;
      nv_cfg_rd_ff <= (req.tgt == ecs_pkg::TGT_NV_CFG);
    end
    else
    begin
      if (st_ff == ecs_pkg::S_PRG_RD)
        prog_ff <= mem_rd & wdata_ff; // programming only clears bits
      if (st_ff == ecs_pkg::S_ERASE && !erase_last)
        cur_idx_ff <= cur_idx_ff + 10'h001;
    end
  end

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
    begin
      hv_cnt_ff <= '0;
      tb_cnt_ff <= 16'h0000;
      tick_ff   <= 1'b0;
    end
    else
    begin
      if (st_ff != ecs_pkg::S_HV)
        hv_cnt_ff <= '0;
      else if (tick_ff && hv_cnt_ff != HV_LAST)
        hv_cnt_ff <= hv_cnt_ff + HW'(1);
      tick_ff   <= (tb_cnt_ff >= div_m1);
      tb_cnt_ff <= (tb_cnt_ff >= div_m1) ? 16'h0000 : tb_cnt_ff + 16'h0001;
    end
  end

  assign MEM_ACK_OUT          = ack_ff;
  assign MEM_ERR_OUT          = err_ff;
  assign MEM_RDATA_OUT        = rdata_ff;
  assign ARRAY_CONFIG_OUT     = cfg_ff;
  assign TIMEBASE_DIVIDER_OUT = div_ff;
  assign BLOCK_PROTECT_OUT    = bp_ff;
  assign CONFIG_VALID_OUT     = valid_ff;
  assign TIMEBASE_TICK_OUT    = tick_ff;
  assign PUMP_ON_OUT          = pump_ff;
  assign BUSY_OUT             = busy_ff;

  property p_window;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    accept && is_array && !in_window |=> MEM_ACK_OUT && MEM_ERR_OUT;
  endproperty
  a_window: assert property (p_window) else $error("out-of-window access not refused");

  property p_pump;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    $rose(st_ff == ecs_pkg::S_HV) |-> PUMP_ON_OUT ##1 !mem_we;
  endproperty
  a_pump: assert property (p_pump) else $error("pump not on while high voltage phase");

  property p_erase_ones;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (st_ff == ecs_pkg::S_ERASE) && mem_we |-> mem_wd == 8'hff && !erase_locked;
  endproperty
  a_erase_ones: assert property (p_erase_ones) else $error("erase wrote non-erased value");

  property p_manual_hold;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (st_ff == ecs_pkg::S_HV) && !auto_ff && !HV_STOP_IN |=> st_ff == ecs_pkg::S_HV;
  endproperty
  a_manual_hold: assert property (p_manual_hold) else $error("manual pulse ended without stop");

  property p_rd_prot;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    accept && rd_locked |=> MEM_ERR_OUT && MEM_RDATA_OUT == 8'h00;
  endproperty
  a_rd_prot: assert property (p_rd_prot) else $error("protected read returned data");

  property p_load_cfg;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (st_ff == ecs_pkg::S_LD_DATA) && ld_idx_ff == 2'h0 |=> ARRAY_CONFIG_OUT == $past(mem_rd)
      && BLOCK_PROTECT_OUT == $past(mem_rd[3:0]);
  endproperty
  a_load_cfg: assert property (p_load_cfg) else $error("config byte not loaded into shadow");

  property p_load_div;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (st_ff == ecs_pkg::S_LD_DATA) && ld_idx_ff == 2'h1 |=> TIMEBASE_DIVIDER_OUT[15:8] == $past(mem_rd)
      ##2 TIMEBASE_DIVIDER_OUT[7:0] == $past(mem_rd);
  endproperty
  a_load_div: assert property (p_load_div) else $error("divider halves not loaded");

  property p_shadow_wr;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    shd_wr && SHADOW_WR_IN.sel == ecs_pkg::SHD_CFG |=> ARRAY_CONFIG_OUT == $past(SHADOW_WR_IN.data);
  endproperty
  a_shadow_wr: assert property (p_shadow_wr) else $error("shadow write lost");

  property p_bp_refresh;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    (st_ff == ecs_pkg::S_READ) && nv_cfg_rd_ff |=> BLOCK_PROTECT_OUT == $past(mem_rd[3:0]);
  endproperty
  a_bp_refresh: assert property (p_bp_refresh) else $error("block protect not refreshed");

  property p_blk_lock;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    accept && req.op == ecs_pkg::OP_PROG && blk_locked |=> MEM_ERR_OUT ##0 st_ff == ecs_pkg::S_IDLE;
  endproperty
  a_blk_lock: assert property (p_blk_lock) else $error("program into locked block accepted");

  property p_load_first;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    !$past(RST_N_IN) |-> !CONFIG_VALID_OUT ##[5:7] CONFIG_VALID_OUT;
  endproperty
  a_load_first: assert property (p_load_first) else $error("configuration load timing wrong");

  property p_tick;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    TIMEBASE_TICK_OUT && $stable(div_ff) && div_ff > 16'h0001 |=> !TIMEBASE_TICK_OUT;
  endproperty
  a_tick: assert property (p_tick) else $error("timebase ticks too often");

endmodule

// *** dv/ecs_cpu_model.sv ***
`timescale 1ns/1ps
module ecs_cpu_model (
  input  wire logic            clk_in,
  input  wire logic            ack_in,
  input  wire logic            err_in,
  input  wire logic [7:0]      rdata_in,
  input  wire logic            busy_in,
  input  wire logic            pump_in,
  output ecs_pkg::ecs_req_type req_out,
  output logic                 auto_out,
  output logic                 stop_out
);
  initial
  begin
    req_out  = '0;
    auto_out = 1'b1;
    stop_out = 1'b0;
  end

  // request held until the edge that samples ack; the block takes nothing while ack stands
  task automatic xfer(input logic [2:0] op, input logic [1:0] tg, input logic [15:0] ad,
                      input logic [7:0] wd, input logic aut, output logic [7:0] rd,
                      output logic er, output logic pmp, output logic to);
    int n;
    n   = 0;
    pmp = 1'b0;
    do @(posedge clk_in); while (busy_in !== 1'b0);
    req_out  <= {1'b1, ecs_pkg::ecs_op_type'(op), ecs_pkg::ecs_tgt_type'(tg), ad, wd};
    auto_out <= aut;
    do
    begin
      @(posedge clk_in);
      n++;
      if (pump_in === 1'b1)
        pmp = 1'b1;
      // manual mode: end the high-voltage phase after a few pump cycles
      stop_out <= !aut && pump_in === 1'b1 && n % 4 == 0 && ack_in !== 1'b1;
    end
    while (ack_in !== 1'b1 && n < 3000);
    rd = rdata_in;
    er = err_in;
    to = ack_in !== 1'b1;
    req_out.valid <= 1'b0;
  endtask
endmodule

// *** dv/ecs_config_loader_tb.sv ***
`timescale 1ns/1ps
module ecs_config_loader_tb;
  localparam int HVT = 2;
  localparam logic [2:0] RD = ecs_pkg::OP_READ;
  localparam logic [2:0] PG = ecs_pkg::OP_PROG;
  localparam logic [2:0] EB = ecs_pkg::OP_ERASE_BYTE;
  localparam logic [2:0] EK = ecs_pkg::OP_ERASE_BLOCK;
  localparam logic [2:0] EA = ecs_pkg::OP_ERASE_BULK;
  logic                 clk = 1'b0;
  logic                 rst_n;
  ecs_pkg::ecs_req_type req;
  ecs_pkg::ecs_shd_type shd;
  logic                 auto_t;
  logic                 stop;
  logic                 mon;
  logic                 ack;
  logic                 err;
  logic                 valid;
  logic                 tick;
  logic                 pump;
  logic                 busy;
  logic [7:0]           rdata;
  logic [7:0]           cfg;
  logic [15:0]          div;
  logic [3:0]           bp;
  logic [7:0]           mem_exp [512];
  logic [7:0]           rd;
  logic [7:0]           d;
  logic                 er;
  logic                 pm;
  logic                 to;
  int                   n_fail;
  int                   samples_checked;
  int                   k;
  int                   a;

  always #50 clk = ~clk;

  ecs_config_loader #(.HV_TICKS(HVT)) dut (
    .CLK_SYS_IN           (clk),
    .RST_N_IN             (rst_n),
    .MEM_REQ_IN           (req),
    .SHADOW_WR_IN         (shd),
    .AUTO_TIMING_IN       (auto_t),
    .HV_STOP_IN           (stop),
    .MONITOR_MODE_IN      (mon),
    .MEM_ACK_OUT          (ack),
    .MEM_ERR_OUT          (err),
    .MEM_RDATA_OUT        (rdata),
    .ARRAY_CONFIG_OUT     (cfg),
    .TIMEBASE_DIVIDER_OUT (div),
    .BLOCK_PROTECT_OUT    (bp),
    .CONFIG_VALID_OUT     (valid),
    .TIMEBASE_TICK_OUT    (tick),
    .PUMP_ON_OUT          (pump),
    .BUSY_OUT             (busy)
  );

  ecs_cpu_model cpu (
    .clk_in   (clk),
    .ack_in   (ack),
    .err_in   (err),
    .rdata_in (rdata),
    .busy_in  (busy),
    .pump_in  (pump),
    .req_out  (req),
    .auto_out (auto_t),
    .stop_out (stop)
  );

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic acc(input logic [2:0] op, input logic [1:0] tg, input logic [15:0] ad,
                     input logic [7:0] wd = 8'h00, input logic aut = 1'b1);
    cpu.xfer(op, tg, ad, wd, aut, rd, er, pm, to);
    chk(16'(to), 16'h0000, "no answer");
  endtask

  task automatic shw(input logic [1:0] sel, input logic [7:0] dv);
    shd <= {1'b1, ecs_pkg::ecs_shd_sel_type'(sel), dv};
    @(posedge clk);
    shd.valid <= 1'b0;
    @(posedge clk);
  endtask

  task automatic do_reset(input logic [7:0] ecfg, input logic [15:0] ediv);
    int i;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk(16'(valid), 16'h0000, "valid in reset");
    rst_n <= 1'b1;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
      if (valid !== 1'b1)
        chk(16'(busy), 16'h0001, "busy while loading");
    end
    while (valid !== 1'b1 && i < 20);
    chk(16'(cfg), 16'(ecfg), "cfg loaded");
    chk(div, ediv, "divider loaded");
    chk(16'(bp), 16'(ecfg[3:0]), "protect loaded");
  endtask

  initial
  begin
    rst_n           = 1'b0;
    shd             = '0;
    mon             = 1'b0;
    n_fail          = 0;
    samples_checked = 0;
    for (k = 0; k < 512; k++)
      mem_exp[k] = 8'hff;
    void'($urandom(32'h5634));
    do_reset(8'hff, 16'hffff);
    $display("test reset done");
    shw(2'h1, 8'h00);
    shw(2'h2, 8'h04);
    chk(div, 16'h0004, "divider shadow");
    d = 8'($urandom);
    shw(2'h0, d);
    chk(16'({bp, cfg}), 16'({4'hf, d}), "cfg shadow");
    repeat (8) @(posedge clk);
    k = 0;
    repeat (40)
    begin
      @(posedge clk);
      if (tick === 1'b1)
        k++;
    end
    chk(16'(k), 16'h000a, "tick count");
    $display("test shadow done");
    acc(RD, 2'h0, 16'h05ff);
    chk(16'({er, rd}), 16'h0100, "below window");
    acc(RD, 2'h0, 16'h0800);
    chk(16'({er, rd}), 16'h0100, "above window");
    acc(RD, 2'h0, 16'h0600);
    chk(16'({er, rd}), 16'h00ff, "erased read");
    acc(PG, 2'h0, 16'h07ff, 8'h00);
    chk(16'(er), 16'h0001, "locked prog");
    acc(3'h5, 2'h0, 16'h0600);
    chk(16'(er), 16'h0001, "bad op");
    acc(EK, 2'h1, 16'h0000);
    chk(16'(er), 16'h0001, "nv block erase");
    acc(PG, 2'h1, 16'h0000, 8'hf0);
    acc(RD, 2'h1, 16'h0000);
    chk(16'({er, rd}), 16'h00f0, "nv cfg prog");
    chk(16'({bp, cfg}), 16'({4'h0, d}), "protect refresh");
    acc(PG, 2'h2, 16'h0000, 8'h00);
    acc(PG, 2'h3, 16'h0000, 8'h04);
    $display("test window done");
    for (k = 0; k < 6; k++)
    begin
      a = k < 2 ? 0 : k == 2 ? 511 : int'($urandom % 512);
      d = 8'($urandom);
      acc(PG, 2'h0, 16'h0600 + 16'(a), d, k[0]);
      mem_exp[a] = mem_exp[a] & d;
      chk(16'({er, pm}), 16'h0001, "prog pump");
      acc(RD, 2'h0, 16'h0600 + 16'(a));
      chk(16'({er, rd}), 16'(mem_exp[a]), "readback");
    end
    $display("test program done");
    acc(EB, 2'h0, 16'h0600);
    acc(RD, 2'h0, 16'h0600);
    chk(16'({er, rd}), 16'h00ff, "byte erase");
    acc(PG, 2'h0, 16'h0690, 8'h5a);
    acc(PG, 2'h0, 16'h0700, 8'h3c);
    acc(EK, 2'h0, 16'h06c0);
    acc(RD, 2'h0, 16'h0690);
    chk(16'(rd), 16'h00ff, "block erase");
    acc(RD, 2'h0, 16'h0700);
    chk(16'(rd), 16'(mem_exp[256] & 8'h3c), "other block kept");
    acc(PG, 2'h0, 16'h06a0, 8'h11);
    acc(EB, 2'h1, 16'h0000);
    acc(PG, 2'h1, 16'h0000, 8'hf2);
    acc(RD, 2'h1, 16'h0000);
    chk(16'({bp, rd}), 16'h02f2, "relock");
    acc(PG, 2'h0, 16'h0690, 8'h00);
    chk(16'(er), 16'h0001, "block 1 locked");
    acc(EA, 2'h0, 16'h0600);
    acc(RD, 2'h0, 16'h0700);
    chk(16'(rd), 16'h00ff, "bulk erase");
    acc(RD, 2'h0, 16'h06a0);
    chk(16'(rd), 16'h0011, "bulk skips locked");
    $display("test erase done");
    shw(2'h0, 8'h10);
    mon <= 1'b1;
    acc(RD, 2'h0, 16'h0700);
    chk(16'({er, rd}), 16'h0100, "monitor read");
    mon <= 1'b0;
    acc(RD, 2'h0, 16'h0700);
    chk(16'({er, rd}), 16'h00ff, "normal read");
    $display("test protect done");
    do_reset(8'hf2, 16'h0004);
    $display("test reload done");
    summarize();
  end

  // a bulk erase takes over 512 cycles here, a block erase over 128, the other requests well under 100
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    summarize();
  end
endmodule
